// File: ssp_consts.svh
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// Register index within one port (address bits [3:0])
`define REG_MODE        4'h0
`define REG_CLKSEL      4'h1
`define REG_RX_WORD     4'h2
`define REG_RX_BYTE     4'h3
`define REG_PEEK_WORD   4'h4
`define REG_PEEK_BYTE   4'h5
`define REG_TX_WORD     4'h6
`define REG_TX_BYTE     4'h7
`define REG_FIRST_WORD  4'h8
`define REG_FIRST_BYTE  4'h9

// Port select field of the address
`define ADDR_PORT_LSB   4
`define ADDR_PORT_MSB   5
`define ADDR_TOP_LSB    6
`define ADDR_TOP_MSB    7

// Mode register field positions
`define MODE_ENABLE_BIT 7
`define MODE_ACTIVE_BIT 0

// Reset values and writable bits
`define MODE_RESET      8'h00
`define CLKSEL_RESET    8'h00
`define MODE_WR_MASK    8'hfc
`define CLKSEL_WR_MASK  8'h1f

// Clock source codes
`define SRC_TIMER       3'h6
`define SRC_SLAVE       3'h7

// Bits per word
`define BITS_SHORT      5'd8
`define BITS_LONG       5'd16

`endif

// File: ssp_pkg.sv
`default_nettype none

package ssp_pkg;

   typedef struct packed {
      logic enable;
      logic duplex;
      logic len16;
      logic lsb_first;
      logic irq_delay;
      logic continuous;
      logic zero;
      logic active;
   } mode_t;

   typedef struct packed {
      logic [2:0] zero;
      logic       idle_low;
      logic       early_data;
      logic [2:0] src;
   } clksel_t;

   typedef struct packed {
      logic sck_o;
      logic sck_oe_n;
      logic so;
   } link_out_t;

   typedef enum logic [1:0] {
      XFER_IDLE  = 2'b01,
      XFER_SHIFT = 2'b10
   } xfer_state_t;

endpackage

`default_nettype wire

// File: sync_serial_port.sv
// Summary of operation
// - Three independent ports, each with own registers, pins and completion interrupt.
// - Word length is eight or sixteen bits; exactly that many bits shift.
// - Software picks MSB-first or LSB-first for transmit and receive.
// - Eight clock sources: seven internal make master, external pin clock makes slave.
// - Link has data out, data in and a bidirectional serial clock.
// - One interrupt request, raised when a transfer completes.
// - Software selects transmit-and-receive or receive-only operation.
// - Single or continuous transfer mode, selected by software.
// - One sixteen-bit shift register shared by transmit and receive, in and out together.
// - Shift register works from MSB or LSB end per bit order.
// - Transfers start only from a buffer register access, no start bit.
// - Sixteen-bit receive buffer, low byte also readable alone.
// - Read-only receive buffer view returns the same data without side effect.
// - Sixteen-bit transmit buffer with an eight-bit low-byte view.
// - Initial transmit buffer supplies the first word in continuous mode.
// - Clock controller gates shift clock and drives the pin in master mode.
// - Clock counter detects when eight or sixteen bits have been exchanged.
// - Interrupt timing logic places the request relative to the serial clock.
// - Eight-bit mode register plus eight-bit clock select and timing register.
// - Receive-only holds data out low; reading primary receive buffer starts reception.
// - In transmit-and-receive mode writing the transmit buffer starts a transfer.
// - Clock select code 111B means external pin clock and slave mode.
//
// The register offsets and the strobed register port were chosen for this implementation.
`include "ssp_consts.svh"
`default_nettype none

module ssp_channel
   import ssp_pkg::*;
(
   input  wire logic        clk,        // System clock
   input  wire logic        rst_n,      // Synchronised reset, active low
   input  wire logic        wr,         // Write strobe for this port
   input  wire logic        rd,         // Read strobe for this port
   input  wire logic [3:0]  idx,        // Register index
   input  wire logic [15:0] wdata,      // Write data
   output logic      [15:0] rd_val,     // Read value, combinational
   input  wire logic        sck_in,     // Serial clock pin, asynchronous
   input  wire logic        si_in,      // Serial data pin, asynchronous
   input  wire logic        timer_tick, // Half-period pulse for source 110B
   output link_out_t        link,       // Clock and data pin drive
   output logic             irq         // Completion pulse
);

   mode_t       mode_reg;
   clksel_t     clksel_reg;
   xfer_state_t state_reg;
   logic [15:0] tx_word_buffer_reg;
   logic [15:0] first_tx_word_buffer_reg;
   logic [15:0] rx_word_buffer_reg;
   logic [15:0] word_shift_reg;
   logic [4:0]  bit_cnt_reg;
   logic [4:0]  div_cnt_reg;
   logic        pending_reg;
   logic        sck_lvl_reg;
   logic        so_reg;
   logic        irq_reg;
   logic        irq_wait_reg;
   logic        sck_meta_reg;
   logic        sck_sync_reg;
   logic        sck_prev_reg;
   logic        si_meta_reg;
   logic        si_sync_reg;

   logic        port_rst_n;
   logic        master;
   logic        busy;
   logic        tick;
   logic        lead;
   logic        sample;
   logic        last_bit;
   logic        word_done;
   logic        trig;
   logic        start;
   logic        carry_on;
   logic        tx_wr;
   logic        delayed_irq;
   logic [15:0] tx_val;
   logic [15:0] load_val;
   logic [15:0] shifted;
   logic [15:0] reload_val;
   logic [4:0]  nbits;

   // Half-period mask: source k gives fxx/2^(k+1), so 2^k cycles per half
   function automatic logic [4:0] half_mask(input logic [2:0] src);
      logic [4:0] m;
      m = 5'h00;
      case (src)
         3'h1:    m = 5'h01;
         3'h2:    m = 5'h03;
         3'h3:    m = 5'h07;
         3'h4:    m = 5'h0f;
         3'h5:    m = 5'h1f;
         default: m = 5'h00;
      endcase
      return m;
   endfunction

   function automatic logic out_bit(input logic [15:0] v, input logic len16, input logic lsb);
      return lsb ? v[0] : (len16 ? v[15] : v[7]);
   endfunction

   function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b,
                                            input logic len16, input logic lsb);
      logic [15:0] r;
      r = {v[14:0], b};
      if (lsb) begin
         r = len16 ? {b, v[15:1]} : {v[15:8], b, v[7:1]};
      end
      return r;
   endfunction

   // Enable low holds the port logic in reset
   assign port_rst_n  = rst_n & mode_reg.enable;
   assign master      = (clksel_reg.src != `SRC_SLAVE);
   assign busy        = (state_reg == XFER_SHIFT);
   assign nbits       = mode_reg.len16 ? `BITS_LONG : `BITS_SHORT;
   assign last_bit    = (bit_cnt_reg == nbits - 5'd1);
   assign tx_wr       = wr & ((idx == `REG_TX_WORD) | (idx == `REG_TX_BYTE));
   assign tx_val      = (idx == `REG_TX_BYTE) ? {tx_word_buffer_reg[15:8], wdata[7:0]} : wdata;
   assign delayed_irq = mode_reg.irq_delay & master;

   // Only a buffer access triggers a word
   assign trig = mode_reg.duplex ? tx_wr
               : (rd & ((idx == `REG_RX_WORD) | (idx == `REG_RX_BYTE)));
   assign start = trig & ~busy & mode_reg.enable;

   // Internal tick or synchronised pin edges clock the shifter
   assign tick = (clksel_reg.src == `SRC_TIMER) ? timer_tick
               : ((div_cnt_reg & half_mask(clksel_reg.src)) == half_mask(clksel_reg.src));

   always_comb begin
      lead   = 1'b0;
      sample = 1'b0;
      if (busy) begin
         if (master) begin
            lead   = tick & sck_lvl_reg;
            sample = tick & ~sck_lvl_reg;
         end else begin
            lead   = (sck_prev_reg ^ clksel_reg.idle_low) & ~(sck_sync_reg ^ clksel_reg.idle_low);
            sample = ~(sck_prev_reg ^ clksel_reg.idle_low) & (sck_sync_reg ^ clksel_reg.idle_low);
         end
      end
   end

   assign word_done  = sample & last_bit;
   assign carry_on   = mode_reg.continuous & (pending_reg | trig);
   assign shifted    = shift_in(word_shift_reg, si_sync_reg, mode_reg.len16, mode_reg.lsb_first);
   assign reload_val = tx_wr ? tx_val : tx_word_buffer_reg;
   // Continuous transmit opens with the initial buffer
   assign load_val   = ~mode_reg.duplex ? 16'h0000
                     : (mode_reg.continuous ? first_tx_word_buffer_reg : tx_val);

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_meta_reg <= 1'b1;
         sck_sync_reg <= 1'b1;
         sck_prev_reg <= 1'b1;
         si_meta_reg  <= 1'b0;
         si_sync_reg  <= 1'b0;
      end else begin
         sck_meta_reg <= sck_in;
         sck_sync_reg <= sck_meta_reg;
         sck_prev_reg <= sck_sync_reg;
         si_meta_reg  <= si_in;
         si_sync_reg  <= si_meta_reg;
      end
   end

   // Mode register; active bit is read-only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= `MODE_RESET;
      end else if (wr && idx == `REG_MODE) begin
         mode_reg <= wdata[7:0] & `MODE_WR_MASK;
      end
   end

   // Clock select only changes while the port is disabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clksel_reg <= `CLKSEL_RESET;
      end else if (wr && idx == `REG_CLKSEL && !mode_reg.enable) begin
         clksel_reg <= wdata[7:0] & `CLKSEL_WR_MASK;
      end
   end

   // Transmit buffers; byte views touch the low byte only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word_buffer_reg       <= 16'h0000;
         first_tx_word_buffer_reg <= 16'h0000;
      end else if (wr) begin
         if (tx_wr) begin
            tx_word_buffer_reg <= tx_val;
         end
         if (idx == `REG_FIRST_WORD) begin
            first_tx_word_buffer_reg <= wdata;
         end else if (idx == `REG_FIRST_BYTE) begin
            first_tx_word_buffer_reg[7:0] <= wdata[7:0];
         end
      end
   end

   // Free-running divider for the master clock
   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         div_cnt_reg <= 5'h00;
      end else begin
         div_cnt_reg <= div_cnt_reg + 5'h01;
      end
   end

   // Transfer sequencing
   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         state_reg <= XFER_IDLE;
      end else begin
         case (state_reg)
            XFER_IDLE: begin
               if (start) begin
                  state_reg <= XFER_SHIFT;
               end
            end
            XFER_SHIFT: begin
               if (word_done && !carry_on) begin
                  state_reg <= XFER_IDLE;
               end
            end
            default: state_reg <= XFER_IDLE;
         endcase
      end
   end

   // Continuous mode: one word queued behind the shifter; consume beats set
   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         pending_reg <= 1'b0;
      end else if (!mode_reg.continuous) begin
         pending_reg <= 1'b0;
      end else if (start) begin
         pending_reg <= mode_reg.duplex;
      end else if (word_done) begin
         pending_reg <= 1'b0;
      end else if (trig && busy) begin
         pending_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         bit_cnt_reg <= 5'd0;
      end else if (start || word_done) begin
         bit_cnt_reg <= 5'd0;
      end else if (sample) begin
         bit_cnt_reg <= bit_cnt_reg + 5'd1;
      end
   end

   // One register shifts out and in together
   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         word_shift_reg <= 16'h0000;
      end else if (start) begin
         word_shift_reg <= load_val;
      end else if (word_done) begin
         word_shift_reg <= (carry_on && mode_reg.duplex) ? reload_val : shifted;
      end else if (sample) begin
         word_shift_reg <= shifted;
      end
   end

   // Received word; eight-bit words clear the upper byte
   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         rx_word_buffer_reg <= 16'h0000;
      end else if (word_done) begin
         rx_word_buffer_reg <= mode_reg.len16 ? shifted : {8'h00, shifted[7:0]};
      end
   end

   // Data out: late mode changes on the leading edge, early mode after sampling
   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         so_reg <= 1'b0;
      end else if (!mode_reg.duplex) begin
         so_reg <= 1'b0;
      end else if (clksel_reg.early_data) begin
         if (start) begin
            so_reg <= out_bit(load_val, mode_reg.len16, mode_reg.lsb_first);
         end else if (word_done && carry_on) begin
            so_reg <= out_bit(reload_val, mode_reg.len16, mode_reg.lsb_first);
         end else if (sample && !last_bit) begin
            so_reg <= out_bit(shifted, mode_reg.len16, mode_reg.lsb_first);
         end
      end else if (lead) begin
         so_reg <= out_bit(word_shift_reg, mode_reg.len16, mode_reg.lsb_first);
      end
   end

   // Master clock level, idles at its inactive level between words
   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         sck_lvl_reg <= 1'b1;
      end else if (!busy || !master) begin
         sck_lvl_reg <= 1'b1;
      end else if (tick) begin
         sck_lvl_reg <= ~sck_lvl_reg;
      end
   end

   // Completion pulse, half a serial clock later in delay mode with an internal clock
   always_ff @(posedge clk or negedge port_rst_n) begin
      if (!port_rst_n) begin
         irq_reg      <= 1'b0;
         irq_wait_reg <= 1'b0;
      end else begin
         irq_reg <= (word_done & ~delayed_irq) | (irq_wait_reg & tick);
         if (word_done && delayed_irq) begin
            irq_wait_reg <= 1'b1;
         end else if (tick) begin
            irq_wait_reg <= 1'b0;
         end
      end
   end

   // Read mux; peek views have no side effect
   always_comb begin
      rd_val = 16'h0000;
      case (idx)
         `REG_MODE:       rd_val = {8'h00, mode_reg[7:1], busy};
         `REG_CLKSEL:     rd_val = {8'h00, clksel_reg};
         `REG_RX_WORD:    rd_val = rx_word_buffer_reg;
         `REG_RX_BYTE:    rd_val = {8'h00, rx_word_buffer_reg[7:0]};
         `REG_PEEK_WORD:  rd_val = rx_word_buffer_reg;
         `REG_PEEK_BYTE:  rd_val = {8'h00, rx_word_buffer_reg[7:0]};
         `REG_TX_WORD:    rd_val = tx_word_buffer_reg;
         `REG_TX_BYTE:    rd_val = {8'h00, tx_word_buffer_reg[7:0]};
         `REG_FIRST_WORD: rd_val = first_tx_word_buffer_reg;
         `REG_FIRST_BYTE: rd_val = {8'h00, first_tx_word_buffer_reg[7:0]};
         default:         rd_val = 16'h0000;
      endcase
   end

   // Clock pin is driven only in master mode
   assign link.sck_o    = sck_lvl_reg ^ clksel_reg.idle_low;
   assign link.sck_oe_n = ~(mode_reg.enable & master);
   assign link.so       = so_reg;
   assign irq           = irq_reg;

endmodule

module sync_serial_port
   import ssp_pkg::*;
#(
   parameter int PORTS = 3
)(
   input  wire logic             CLK,        // 40 MHz system clock
   input  wire logic             RESETN,     // Asynchronous reset, active low
   input  wire logic [7:0]       ADDR,       // Register address
   input  wire logic [15:0]      WDATA,      // Write data
   input  wire logic             WR,         // Write strobe
   input  wire logic             RD,         // Read strobe
   output logic      [15:0]      RDATA,      // Read data, cycle after RD
   input  wire logic [PORTS-1:0] SCK_IN,     // Serial clock pin input
   output logic      [PORTS-1:0] SCK_OUT,    // Serial clock pin output
   output logic      [PORTS-1:0] SCK_OE_N,   // Serial clock drive enable, low drives
   input  wire logic [PORTS-1:0] SI,         // Serial data input pins
   output logic      [PORTS-1:0] SO,         // Serial data output pins
   input  wire logic [PORTS-1:0] TIMER_TICK, // Timer clock half-period pulses
   output logic      [PORTS-1:0] IRQ         // Completion pulses
);

   logic             rst_meta_reg;
   logic             rst_n_reg;
   logic [15:0]      rd_val [PORTS];
   logic [PORTS-1:0] sel;
   link_out_t        link [PORTS];

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   for (genvar i = 0; i < PORTS; i++) begin : g_port
      assign sel[i] = (ADDR[`ADDR_TOP_MSB:`ADDR_TOP_LSB] == 2'b00)
                    && (ADDR[`ADDR_PORT_MSB:`ADDR_PORT_LSB] == 2'(i));
      ssp_channel u_ch (
         .clk        (CLK),
         .rst_n      (rst_n_reg),
         .wr         (WR & sel[i]),
         .rd         (RD & sel[i]),
         .idx        (ADDR[3:0]),
         .wdata      (WDATA),
         .rd_val     (rd_val[i]),
         .sck_in     (SCK_IN[i]),
         .si_in      (SI[i]),
         .timer_tick (TIMER_TICK[i]),
         .link       (link[i]),
         .irq        (IRQ[i])
      );
      assign SCK_OUT[i]  = link[i].sck_o;
      assign SCK_OE_N[i] = link[i].sck_oe_n;
      assign SO[i]       = link[i].so;
   end

   // Unmapped addresses read as zero
   always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         RDATA <= 16'h0000;
      end else begin
         RDATA <= 16'h0000;
         for (int j = 0; j < PORTS; j++) begin
            if (RD && sel[j]) begin
               RDATA <= rd_val[j];
            end
         end
      end
   end

endmodule

`default_nettype wire

// File: sync_serial_port_props.sv
`default_nettype none
module sync_serial_port_props
   import ssp_pkg::*;
#(
   parameter int PORTS = 3
)(
   input wire logic             CLK,        // Clock
   input wire logic             RESETN,     // Reset
   input wire logic [7:0]       ADDR,       // Address
   input wire logic [15:0]      WDATA,      // Write data
   input wire logic             WR,         // Write
   input wire logic             RD,         // Read
   input wire logic [15:0]      RDATA,      // Read data
   input wire logic [PORTS-1:0] SCK_IN,     // Clock wire
   input wire logic [PORTS-1:0] SCK_OUT,    // Clock drive
   input wire logic [PORTS-1:0] SCK_OE_N,   // Clock enable
   input wire logic [PORTS-1:0] SI,         // Data in
   input wire logic [PORTS-1:0] SO,         // Data out
   input wire logic [PORTS-1:0] TIMER_TICK, // Timer
   input wire logic [PORTS-1:0] IRQ         // Done
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   mode_t      mode0_reg, mode2_reg;
   clksel_t    clk0_reg;
   logic       rd_seen_reg;
   logic [7:0] raddr_reg;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rd_seen_reg <= 1'b0;
         raddr_reg <= 8'h00;
      end else begin
         rd_seen_reg <= RD;
         raddr_reg <= ADDR;
      end
   end
   // Shadow of the written controls; clock select locked while enabled
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         mode0_reg <= '0;
         mode2_reg <= '0;
         clk0_reg <= '0;
      end else if (WR) begin
         if (ADDR == 8'h00) mode0_reg <= mode_t'(WDATA[7:0]);
         if (ADDR == 8'h20) mode2_reg <= mode_t'(WDATA[7:0]);
         if (ADDR == 8'h01 && !mode0_reg.enable) clk0_reg <= clksel_t'(WDATA[7:0]);
      end
   end
   a_rdata_quiet: assert property (!rd_seen_reg |-> RDATA == 16'h0000)
      else $error("read data not zero outside read");
   a_read_unmapped: assert property (rd_seen_reg && (raddr_reg[7:6] != 2'b00 || raddr_reg[5:4] == 2'b11
      || raddr_reg[3:0] > 4'h9) |-> RDATA == 16'h0000) else $error("unmapped read not zero");
   a_byte_upper: assert property (rd_seen_reg && raddr_reg[3:0] inside {4'h0, 4'h1, 4'h3, 4'h5}
      |-> RDATA[15:8] == 8'h00) else $error("byte read upper not zero");
   a_irq_pulse: assert property (IRQ[0] |=> !IRQ[0])
      else $error("done pulse too long");
   a_irq_after_rise: assert property (IRQ[0] |-> SCK_IN[0] && $past(SCK_IN[0]) == SCK_OE_N[0])
      else $error("done not after final clock rise");
   a_so_rxonly: assert property (!mode2_reg.duplex && !$past(mode2_reg.duplex) |-> !SO[2])
      else $error("data out not low in receive-only");
   a_pin_drive: assert property (mode0_reg.enable && $past(mode0_reg.enable)
      |-> SCK_OE_N[0] == (clk0_reg.src == 3'h7)) else $error("clock pin drive wrong for source");
   a_off_quiet: assert property (!mode0_reg.enable && !$past(mode0_reg.enable) |-> SCK_OE_N[0] && !SO[0])
      else $error("pins active while disabled");
   a_start_busy: assert property ((WR && ADDR == 8'h06 && mode0_reg.enable && mode0_reg.duplex)
      ##2 (RD && ADDR == 8'h00) |=> RDATA[0]) else $error("busy not set after start");
   c_done0: cover property (IRQ[0] && !SCK_OE_N[0]);
   c_slave0: cover property (IRQ[0] && SCK_OE_N[0]);
   c_cont1: cover property (IRQ[1] ##[1:100] IRQ[1]);
   c_done2: cover property (IRQ[2]);
endmodule

bind sync_serial_port sync_serial_port_props #(.PORTS(PORTS)) props_i (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N),
   .SI(SI), .SO(SO), .TIMER_TICK(TIMER_TICK), .IRQ(IRQ));
`default_nettype wire

// File: serial_peer.sv
`default_nettype none
module serial_peer (
   input  wire logic        sck,       // Clock wire level
   input  wire logic        so_in,     // Device data out
   output logic             si_out,    // Data to device
   input  wire logic        arm,       // Clears while high
   input  wire logic [15:0] tx_word,   // Word sent back
   input  wire logic        len16,     // Word length
   input  wire logic        lsb_first, // Bit order
   output logic      [15:0] rx_word    // Captured bits
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] bit_cnt;
   logic [3:0] pos;
   assign pos = len16 ? bit_cnt[3:0] : {1'b0, bit_cnt[2:0]};
   initial si_out = 1'b0;
   always @(posedge arm) begin
      bit_cnt = 5'd0;
      rx_word = 16'h0000;
   end
   always @(negedge sck) if (!arm) si_out <= lsb_first ? tx_word[pos] : tx_word[(len16 ? 4'hf : 4'h7) - pos];
   always @(posedge sck) if (!arm) begin
      rx_word <= lsb_first ? {so_in, rx_word[15:1]} : {rx_word[14:0], so_in};
      bit_cnt <= bit_cnt + 5'd1;
   end
   // Hold time over with clock parked high: line no longer shows the bit
   always @(posedge sck) begin
      #120;
      if (sck) si_out <= ~si_out;
   end
endmodule
`default_nettype wire

// File: sync_serial_port_bench.sv
`default_nettype none
module sync_serial_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        CLK, RESETN, WR, RD;
   logic [7:0]  ADDR;
   logic [15:0] WDATA, RDATA, rv;
   logic [2:0]  SCK_OUT, SCK_OE_N, SO, TIMER_TICK, IRQ, slv_clk, arm, plen, plsb;
   wire  [2:0]  SCK_IN, SI;
   logic [15:0] ptx [3];
   wire  [15:0] prx [3];
   logic [1:0]  tick_cnt;
   int          n_mismatch, total_checks, cyc, got, span;
   assign SCK_IN = (SCK_OE_N & slv_clk) | (~SCK_OE_N & SCK_OUT);
   sync_serial_port #(.PORTS(3)) dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .SI(SI), .SO(SO),
      .TIMER_TICK(TIMER_TICK), .IRQ(IRQ));
   for (genvar g = 0; g < 3; g++) begin : peers
      serial_peer peer (.sck(SCK_IN[g]), .so_in(SO[g]), .si_out(SI[g]), .arm(arm[g]), .tx_word(ptx[g]),
         .len16(plen[g]), .lsb_first(plsb[g]), .rx_word(prx[g]));
   end
   initial CLK = 1'b0;
   always #12.5 CLK = ~CLK;
   always @(posedge CLK) begin
      tick_cnt <= tick_cnt + 2'd1;
      TIMER_TICK <= {3{tick_cnt == 2'd3}};
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      @(posedge CLK);
   endtask
   task rd_reg(input logic [7:0] a, output logic [15:0] d);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
      @(posedge CLK);
   endtask
   task wait_irq(input int p, input int want, input int lim);
      int first;
      got = 0;
      span = 0;
      first = 0;
      for (int i = 0; i < lim && got < want; i++) begin
         @(posedge CLK);
         #1;
         if (IRQ[p] === 1'b1) begin
            if (got == 0) first = i;
            got++;
            span = i - first;
         end
      end
      @(posedge CLK);
   endtask
   task arm_peer(input int p, input logic [15:0] t, input logic l16, input logic lsb);
      ptx[p] <= t;
      plen[p] <= l16;
      plsb[p] <= lsb;
      arm[p] <= 1'b1;
      @(posedge CLK);
      arm[p] <= 1'b0;
      @(posedge CLK);
   endtask
   task t_reset;
      for (int p = 0; p < 3; p++) begin
         rd_reg(8'(p * 16), rv);
         chk(rv, 16'h0000);
         rd_reg(8'(p * 16 + 1), rv);
         chk(rv, 16'h0000);
      end
      chk({10'h0, SCK_OE_N, SO}, 16'h0038);
      $display("test reset done");
   endtask
   // Every internal source; slow ones also check the returned byte
   task t_sources;
      for (int s = 0; s < 7; s++) begin
         wr_reg(8'h00, 16'h0000);
         wr_reg(8'h01, 16'(s));
         wr_reg(8'h00, 16'h00c0);
         arm_peer(0, 16'ha5c3, 1'b0, 1'b0);
         wr_reg(8'h06, 16'ha500 | 16'(8'h30 + s));
         rd_reg(8'h00, rv);
         chk(rv & 16'h0001, 16'h0001);
         chk({15'h0, SCK_OE_N[0]}, 16'h0000);
         wait_irq(0, 1, 2000);
         chk(16'(got), 16'h0001);
         chk(prx[0], 16'(8'h30 + s));
         if (s >= 2) begin
            rd_reg(8'h03, rv);
            chk(rv, 16'h00c3);
            rd_reg(8'h04, rv);
            chk(rv, 16'h00c3);
         end
         rd_reg(8'h00, rv);
         chk(rv, 16'h00c0);
      end
      $display("test sources done");
   endtask
   task t_lsb16;
      wr_reg(8'h11, 16'h0002);
      wr_reg(8'h10, 16'h00f0);
      wr_reg(8'h11, 16'h0005);
      rd_reg(8'h11, rv);
      chk(rv, 16'h0002);
      arm_peer(1, 16'hbeef, 1'b1, 1'b1);
      wr_reg(8'h16, 16'h1234);
      wait_irq(1, 1, 500);
      chk(prx[1], 16'h1234);
      rd_reg(8'h12, rv);
      chk(rv, 16'hbeef);
      rd_reg(8'h14, rv);
      chk(rv, 16'hbeef);
      $display("test lsb16 done");
   endtask
   task t_continuous;
      wr_reg(8'h10, 16'h0000);
      wr_reg(8'h10, 16'h00c4);
      arm_peer(1, 16'h0077, 1'b0, 1'b0);
      wr_reg(8'h19, 16'h0011);
      wr_reg(8'h17, 16'hff22);
      wait_irq(1, 2, 500);
      chk(16'(got), 16'h0002);
      chk(16'(span), 16'd64);
      chk(prx[1], 16'h1122);
      rd_reg(8'h13, rv);
      chk(rv, 16'h0077);
      $display("test continuous done");
   endtask
   task t_rxonly;
      wr_reg(8'h21, 16'h0006);
      wr_reg(8'h20, 16'h0088);
      chk({15'h0, SO[2]}, 16'h0000);
      arm_peer(2, 16'h005a, 1'b0, 1'b0);
      rd_reg(8'h23, rv);
      wait_irq(2, 1, 500);
      chk(16'(got), 16'h0001);
      rd_reg(8'h25, rv);
      chk(rv, 16'h005a);
      rd_reg(8'h20, rv);
      chk(rv, 16'h0088);
      $display("test rxonly done");
   endtask
   task t_slave;
      wr_reg(8'h00, 16'h0000);
      wr_reg(8'h01, 16'h0007);
      wr_reg(8'h00, 16'h00c0);
      chk({15'h0, SCK_OE_N[0]}, 16'h0001);
      arm_peer(0, 16'h0069, 1'b0, 1'b0);
      wr_reg(8'h06, 16'h0096);
      repeat (16) begin
         repeat (4) @(posedge CLK);
         slv_clk[0] <= ~slv_clk[0];
      end
      wait_irq(0, 1, 20);
      chk(16'(got), 16'h0001);
      chk(prx[0], 16'h0096);
      rd_reg(8'h03, rv);
      chk(rv, 16'h0069);
      wr_reg(8'h00, 16'h0000);
      rd_reg(8'h03, rv);
      chk(rv, 16'h0000);
      rd_reg(8'h30, rv);
      chk(rv, 16'h0000);
      rd_reg(8'h4a, rv);
      chk(rv, 16'h0000);
      $display("test slave done");
   endtask
   initial begin
      {RESETN, WR, RD, ADDR, WDATA, arm, plen, plsb, tick_cnt, TIMER_TICK} = '0;
      slv_clk = 3'b111;
      for (int p = 0; p < 3; p++) ptx[p] = 16'h0000;
      repeat (8) @(posedge CLK);
      RESETN <= 1'b1;
      repeat (3) @(posedge CLK);
      t_reset();
      t_sources();
      t_lsb16();
      t_continuous();
      t_rxonly();
      t_slave();
      report_and_stop();
   end
endmodule
`default_nettype wire
